// ==== adcrc_pkg.sv ====
// Purpose: constants, carriers and state layout of the converter control block
// Assumes: register index times four is the AXI4-Lite byte address
// Notes:   one package shared by the top module and its assertions
//
// What this block does
// RL1: reference bit clear uses internal level, reference pin stays GPIO; set uses pin.
// RL2: clock field 00 divides by four, 01 none, 10 sixteen, 11 two.
// RL3: software sets run bit to start; only hardware clears it at completion.
// RL4: power bit zero switches resistor reference off; one lets converter operate.
// RL5: channel field 000..101 picks channels 0..5, 111 picks 7, 110 reserved.
// RL6: half-supply detect bit set feeds half supply regardless of channel field.
// RL7: completion loads high byte, clears run bit, sets completion flag.
// RL8: high buffer holds result 11..4 read-only; low nibble holds result 3..0.
// RL9: internal level field 00 analog supply, 01 4 V, 10 3 V, 11 2.5 V.
// RL10: unused detect-register bits and top two low-register bits read zero.
// RL11: shared pin priority: external interrupt, then analog input, then GPIO.
// RL12: each analog-enable bit turns its pin from GPIO into analog input.
// RL13: result buffers keep previous value until the completion update.
package adcrc_pkg;

  // ********************************************************
  // register map
  // ********************************************************
  localparam logic [5:0] IDX_CTRL = 6'h06;
  localparam logic [5:0] IDX_PDC  = 6'h07;
  localparam logic [5:0] IDX_HI   = 6'h08;
  localparam logic [5:0] IDX_LO   = 6'h09;
  localparam logic [5:0] IDX_PIN  = 6'h0a;
  localparam logic [5:0] IDX_STS  = 6'h0b;

  // ********************************************************
  // field positions
  // ********************************************************
  localparam int CTL_REFX  = 7;
  localparam int CTL_CK_HI = 6;
  localparam int CTL_CK_LO = 5;
  localparam int CTL_RUN   = 4;
  localparam int CTL_PWR   = 3;
  localparam int CTL_CH_HI = 2;
  localparam int PDC_HALF  = 2;
  localparam int LO_IRV_HI = 5;
  localparam int LO_IRV_LO = 4;
  localparam int PIN_INT   = 8;
  localparam int STS_DONE  = 0;
  localparam int SHARED_PIN = 1;

  // ********************************************************
  // codes and counts
  // ********************************************************
  localparam logic [1:0] CK_DIV4  = 2'h0;
  localparam logic [1:0] CK_DIV1  = 2'h1;
  localparam logic [1:0] CK_DIV16 = 2'h2;
  localparam logic [1:0] CK_DIV2  = 2'h3;
  localparam logic [3:0] LAST_DIV4  = 4'h3;
  localparam logic [3:0] LAST_DIV1  = 4'h0;
  localparam logic [3:0] LAST_DIV16 = 4'hf;
  localparam logic [3:0] LAST_DIV2  = 4'h1;
  localparam logic [2:0] CH_RSVD  = 3'h6;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_SLV = 2'h2;

  typedef enum logic [1:0] {PF_GPIO, PF_ANA, PF_INT} adcrc_pfn_e;

  // ********************************************************
  // carriers to and from the conversion core, and the block's state layout
  // ********************************************************
  typedef struct packed {
    logic       ref_ext;
    logic       ref_pin_gpio;
    logic [1:0] int_ref;
    logic       pwr_on;
    logic       half_sel;
    logic [2:0] chan;
    logic       chan_ok;
    logic       clk_en;
    logic       start;
  } adcrc_cfg_s;

  typedef struct packed {
    logic        done;
    logic [11:0] data;
  } adcrc_res_s;

  typedef struct packed {
    logic       s1;
    logic       s2;
    logic [7:0] ctrl;
    logic       half;
    logic [1:0] irv;
    logic [7:0] res_hi;
    logic [3:0] res_lo;
    logic [7:0] an_en;
    logic       int_en;
    logic       flag;
    logic [3:0] cnt;
    logic       clk_en;
    logic       start;
    logic       chan_ok;
    adcrc_pfn_e pfn;
    logic [7:0] ana;
    logic       eint;
    logic       aw_got;
    logic [5:0] aw_idx;
    logic       w_got;
    logic [8:0] wd;
    logic [1:0] ws;
    logic       aw_rdy;
    logic       w_rdy;
    logic       b_vld;
    logic [1:0] b_resp;
    logic       ar_rdy;
    logic       r_vld;
    logic [1:0] r_resp;
    logic [8:0] r_data;
  } adcrc_st_s;

  localparam adcrc_st_s ST_RST = '0;

endpackage

// ==== adcrc_top.sv ====
// Purpose: register control of a 12-bit converter behind an AXI4-Lite slave
// Assumes: conversion core and bus run on ref_clk; shared pin is asynchronous
// Notes:   converter clock is a one-cycle enable pulse, not a second clock
`timescale 1ns/10ps
module adcrc_top (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic [7:0]          awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [7:0]          araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  input  wire adcrc_pkg::adcrc_res_s core_res,
  output adcrc_pkg::adcrc_cfg_s    core_cfg,
  input  wire logic                ext_int_pin,
  output logic                     ext_int_q,
  output adcrc_pkg::adcrc_pfn_e    pin_func,
  output logic [7:0]               pin_analog
);
  import adcrc_pkg::*;

  adcrc_st_s q;
  adcrc_st_s d;
  logic [3:0] div_last;

  // ********************************************************
  // converter clock divider
  // ********************************************************
  always_comb begin
    case (q.ctrl[CTL_CK_HI:CTL_CK_LO])
      CK_DIV4:  div_last = LAST_DIV4;
      CK_DIV1:  div_last = LAST_DIV1;
      CK_DIV16: div_last = LAST_DIV16;
      CK_DIV2:  div_last = LAST_DIV2;
      default:  div_last = LAST_DIV4;
    endcase
  end

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    d = q;
    d.s1 = ext_int_pin;
    d.s2 = q.s1;
    d.start = 1'b0;

    // write side: address and data may arrive in either order
    if (awvalid && q.aw_rdy) begin
      d.aw_got = 1'b1;
      d.aw_idx = awaddr[7:2];
    end
    if (wvalid && q.w_rdy) begin
      d.w_got = 1'b1;
      d.wd = wdata[8:0];
      d.ws = wstrb[1:0];
    end
    if (q.b_vld && bready) begin
      d.b_vld = 1'b0;
    end
    if (q.aw_got && q.w_got && !q.b_vld) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.b_vld = 1'b1;
      d.b_resp = RESP_OK;
      case (q.aw_idx)
        IDX_CTRL: begin
          if (q.ws[0]) begin
            d.ctrl[7:5] = q.wd[7:5];
            d.ctrl[CTL_PWR:0] = q.wd[CTL_PWR:0];
            // a zero in the run bit is ignored
            if (q.wd[CTL_RUN] && !q.ctrl[CTL_RUN]) begin // RL3
              d.ctrl[CTL_RUN] = 1'b1;
              d.start = 1'b1;
            end
          end
        end
        IDX_PDC: begin
          if (q.ws[0]) begin
            d.half = q.wd[PDC_HALF];
          end
        end
        IDX_HI: begin
          d.b_resp = RESP_OK; // RL8
        end
        IDX_LO: begin
          if (q.ws[0]) begin
            d.irv = q.wd[LO_IRV_HI:LO_IRV_LO];
          end
        end
        IDX_PIN: begin
          if (q.ws[0]) begin
            d.an_en = q.wd[7:0];
          end
          if (q.ws[1]) begin
            d.int_en = q.wd[PIN_INT];
          end
        end
        IDX_STS: begin
          if (q.ws[0] && q.wd[STS_DONE]) begin
            d.flag = 1'b0;
          end
        end
        default: begin
          d.b_resp = RESP_SLV;
        end
      endcase
    end

    // completion; buffers untouched until here, flag set beats clear
    if (q.ctrl[CTL_RUN] && core_res.done) begin // RL13
      d.res_hi = core_res.data[11:4]; // RL7
      d.res_lo = core_res.data[3:0]; // RL8
      d.ctrl[CTL_RUN] = 1'b0; // RL3
      d.flag = 1'b1; // RL7
    end

    // read side
    if (q.r_vld && rready) begin
      d.r_vld = 1'b0;
    end
    if (arvalid && q.ar_rdy) begin
      d.r_vld = 1'b1;
      d.r_resp = RESP_OK;
      d.r_data = '0;
      case (araddr[7:2])
        IDX_CTRL: d.r_data[7:0] = q.ctrl;
        IDX_PDC:  d.r_data[PDC_HALF] = q.half; // RL10
        IDX_HI:   d.r_data[7:0] = q.res_hi;
        IDX_LO:   d.r_data[5:0] = {q.irv, q.res_lo}; // RL10
        IDX_PIN:  d.r_data = {q.int_en, q.an_en};
        IDX_STS:  d.r_data[STS_DONE] = q.flag;
        default:  d.r_resp = RESP_SLV;
      endcase
    end

    // restart the divider when the rate changes so no short period slips out
    if (d.ctrl[CTL_CK_HI:CTL_CK_LO] != q.ctrl[CTL_CK_HI:CTL_CK_LO]) begin
      d.cnt = '0;
      d.clk_en = 1'b0;
    end else if (q.cnt >= div_last) begin // RL2
      d.cnt = '0;
      d.clk_en = 1'b1;
    end else begin
      d.cnt = q.cnt + 4'h1;
      d.clk_en = 1'b0;
    end

    d.chan_ok = !d.half && (d.ctrl[CTL_CH_HI:0] != CH_RSVD); // RL5 RL6

    // shared pin priority
    if (d.int_en) begin // RL11
      d.pfn = PF_INT;
    end else if (d.an_en[SHARED_PIN]) begin
      d.pfn = PF_ANA;
    end else begin
      d.pfn = PF_GPIO;
    end
    d.ana = d.an_en; // RL12
    if (d.int_en) begin
      d.ana[SHARED_PIN] = 1'b0; // RL11
    end
    d.eint = (d.pfn == PF_INT) && q.s2;

    d.aw_rdy = !d.aw_got && !d.b_vld;
    d.w_rdy = !d.w_got && !d.b_vld;
    d.ar_rdy = !d.r_vld;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // ********************************************************
  // outputs, all from state bits, ref_pin_gpio through an inverter
  // ********************************************************
  assign awready = q.aw_rdy;
  assign wready = q.w_rdy;
  assign bvalid = q.b_vld;
  assign bresp = q.b_resp;
  assign arready = q.ar_rdy;
  assign rvalid = q.r_vld;
  assign rresp = q.r_resp;
  assign rdata = {23'h00_0000, q.r_data};
  assign core_cfg.ref_ext = q.ctrl[CTL_REFX]; // RL1
  assign core_cfg.ref_pin_gpio = !q.ctrl[CTL_REFX]; // RL1
  assign core_cfg.int_ref = q.irv; // RL9
  assign core_cfg.pwr_on = q.ctrl[CTL_PWR]; // RL4
  assign core_cfg.half_sel = q.half; // RL6
  assign core_cfg.chan = q.ctrl[CTL_CH_HI:0]; // RL5
  assign core_cfg.chan_ok = q.chan_ok;
  assign core_cfg.clk_en = q.clk_en;
  assign core_cfg.start = q.start;
  assign ext_int_q = q.eint;
  assign pin_func = q.pfn;
  assign pin_analog = q.ana;

  // ********************************************************
  // assertions
  // ********************************************************
  logic ctl_wr_now;

  // control register write performed this cycle; checks that fields follow software
  assign ctl_wr_now = q.aw_got && q.w_got && !q.b_vld
                      && (q.aw_idx == IDX_CTRL) && q.ws[0];

  sequence s_busy_done;
    q.ctrl[CTL_RUN] && core_res.done;
  endsequence

  sequence s_sixteen_gap;
    (q.clk_en && q.ctrl[6:5] == CK_DIV16) ##1
      (q.ctrl[6:5] == CK_DIV16)[*7] ##1 (q.ctrl[6:5] == CK_DIV16);
  endsequence

  a_run_hw_clear: assert property (@(posedge ref_clk) disable iff (rst) // RL3
    $fell(q.ctrl[CTL_RUN]) |-> $past(core_res.done) && q.flag)
    else $error("run bit cleared without completion");

  a_start_pulse: assert property (@(posedge ref_clk) disable iff (rst) // RL3
    $rose(q.ctrl[CTL_RUN]) |-> core_cfg.start)
    else $error("run bit set without start pulse");

  a_done_high_load: assert property (@(posedge ref_clk) disable iff (rst) // RL7
    s_busy_done |=> q.res_hi == $past(core_res.data[11:4]) && !q.ctrl[CTL_RUN]
    && q.flag)
    else $error("completion did not load high byte");

  a_done_low_load: assert property (@(posedge ref_clk) disable iff (rst) // RL8
    s_busy_done |=> q.res_lo == $past(core_res.data[3:0]))
    else $error("completion did not load low nibble");

  a_result_hold: assert property (@(posedge ref_clk) disable iff (rst) // RL13
    !(q.ctrl[CTL_RUN] && core_res.done) |=> $stable(q.res_hi)
    && $stable(q.res_lo))
    else $error("result changed without completion");

  a_div_sixteen: assert property (@(posedge ref_clk) disable iff (rst) // RL2
    s_sixteen_gap |-> !q.clk_en)
    else $error("divide by sixteen pulse too early");

  a_div_none: assert property (@(posedge ref_clk) disable iff (rst) // RL2
    (q.ctrl[6:5] == CK_DIV1)[*2] |-> q.clk_en)
    else $error("undivided clock enable missing");

  a_half_select: assert property (@(posedge ref_clk) disable iff (rst) // RL6
    q.half |-> core_cfg.half_sel && !core_cfg.chan_ok)
    else $error("half supply not forced");

  a_rsvd_chan: assert property (@(posedge ref_clk) disable iff (rst) // RL5
    q.ctrl[2:0] == CH_RSVD |-> !core_cfg.chan_ok)
    else $error("reserved channel routed");

  a_unused_zero: assert property (@(posedge ref_clk) disable iff (rst) // RL10
    $past(arvalid && arready && araddr[7:2] == IDX_PDC)
    |-> rdata[7:3] == 5'h00 && rdata[1:0] == 2'h0)
    else $error("unused detect bits read nonzero");

  a_low_top_zero: assert property (@(posedge ref_clk) disable iff (rst) // RL10
    $past(arvalid && arready && araddr[7:2] == IDX_LO)
    |-> rdata[7:6] == 2'h0)
    else $error("unused low register bits read nonzero");

  a_pin_priority: assert property (@(posedge ref_clk) disable iff (rst) // RL11
    q.int_en |-> pin_func == PF_INT && !pin_analog[SHARED_PIN])
    else $error("interrupt lost shared pin priority");

  a_analog_enable: assert property (@(posedge ref_clk) disable iff (rst) // RL12
    $rose(q.an_en[0]) |-> pin_analog[0])
    else $error("analog enable did not reach pin");

  a_ref_source: assert property (@(posedge ref_clk) disable iff (rst) // RL1
    ctl_wr_now |=> core_cfg.ref_ext == $past(q.wd[CTL_REFX])
    && core_cfg.ref_pin_gpio == !$past(q.wd[CTL_REFX]))
    else $error("reference source did not follow write");

  a_power_follow: assert property (@(posedge ref_clk) disable iff (rst) // RL4
    ctl_wr_now |=> core_cfg.pwr_on == $past(q.wd[CTL_PWR]))
    else $error("power control not followed");

endmodule

// ==== adcrc_core_model.sv ====
// Purpose: behavioural conversion core facing the control block
// Assumes: runs on ref_clk, counts converter clock enables
// Notes:   data is inverted outside the done cycle so early loads show
`timescale 1ns/10ps
module adcrc_core_model #(
  parameter int          CONV_TICKS = 20,
  parameter logic [11:0] SAMPLE     = 12'ha5c
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire adcrc_pkg::adcrc_cfg_s cfg,
  output adcrc_pkg::adcrc_res_s    res
);
  import adcrc_pkg::*;
  logic     busy_q;
  int       cnt_q;
  always_ff @(posedge ref_clk) begin
    res.done <= 1'b0;
    res.data <= ~SAMPLE;
    if (rst) begin
      busy_q <= 1'b0;
      cnt_q  <= 0;
    end else if (cfg.start && cfg.pwr_on) begin
      busy_q <= 1'b1;
      cnt_q  <= 0;
    end else if (busy_q && cfg.clk_en) begin
      cnt_q <= cnt_q + 1;
      if (cnt_q == CONV_TICKS - 1) begin
        busy_q   <= 1'b0;
        res.done <= 1'b1;
        res.data <= SAMPLE;
      end
    end
  end
endmodule

// ==== tb_adc_register_control.sv ====
// Purpose: self-checking bench of the converter control block
// Assumes: byte address is register index times four
// Notes:   handshakes are observed at the falling edge, acted on at the rising one
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_adc_register_control;
  import adcrc_pkg::*;
  logic ref_clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rv;
  logic [3:0] wstrb = '0;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid, ext_int_pin = 1, ext_int_q;
  adcrc_res_s core_res;
  adcrc_cfg_s core_cfg;
  adcrc_pfn_e pin_func;
  logic [7:0] pin_analog;
  int errors = 0, cmp_count = 0, cyc = 0, n;
  int div_exp [4] = '{4, 1, 16, 2};
  logic [7:0] row_a [5] = '{8'h1c, 8'h24, 8'h20, 8'h18, 8'h18};
  logic [31:0] row_e [5] = '{32'h0000_0004, 32'h0000_0030, 32'h0000_0000,
                             32'h0000_00ef, 32'h0000_000e};
  always #25 ref_clk = ~ref_clk;
  adcrc_top dut (.ref_clk(ref_clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .core_res(core_res), .core_cfg(core_cfg), .ext_int_pin(ext_int_pin),
    .ext_int_q(ext_int_q), .pin_func(pin_func), .pin_analog(pin_analog));
  adcrc_core_model core (.ref_clk(ref_clk), .rst(rst), .cfg(core_cfg), .res(core_res));
  task automatic tally_and_finish;
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw, ta, tw;
    pa = 1;
    pw = 1;
    @(posedge ref_clk);
    awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (pa || pw) begin
      @(negedge ref_clk);
      ta = awready & pa;
      tw = wready & pw;
      @(posedge ref_clk);
      if (ta) begin awvalid <= 0; pa = 0; end
      if (tw) begin wvalid <= 0; pw = 0; end
    end
    do @(negedge ref_clk); while (bvalid !== 1'b1);
    resp = bresp;
    @(posedge ref_clk);
    bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(negedge ref_clk); while (arready !== 1'b1);
    @(posedge ref_clk);
    arvalid <= 0;
    do @(negedge ref_clk); while (rvalid !== 1'b1);
    rv = rdata;
    resp = rresp;
    @(posedge ref_clk);
    rready <= 0;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 0;
    for (int i = 0; i < 5; i++) begin
      wr(row_a[i], 32'h0000_00ff & row_e[i] | (i < 3 ? 32'h0000_00ff : 32'h0));
      rd(row_a[i]);
      `CHK(rv, row_e[i])
    end
    `CHK(core_cfg.ref_pin_gpio, 1'b1)
    `CHK(core_cfg.half_sel, 1'b1)
    `CHK(core_cfg.chan_ok, 1'b0)
    `CHK(core_cfg.int_ref, 2'h3)
    `CHK(core_cfg.pwr_on, 1'b1)
    wr(8'h1c, 32'h0); wr(8'h18, 32'h0000_0085);
    `CHK({core_cfg.ref_ext, core_cfg.ref_pin_gpio, core_cfg.chan}, 5'b10_101)
    `CHK({core_cfg.half_sel, core_cfg.chan_ok}, 2'b01)
    for (int i = 0; i < 4; i++) begin
      wr(8'h18, {24'h0, 1'b0, i[1:0], 5'h08});
      do @(negedge ref_clk); while (core_cfg.clk_en !== 1'b1);
      n = 0;
      do begin @(negedge ref_clk); n++; end while (core_cfg.clk_en !== 1'b1);
      `CHK(n, div_exp[i])
    end
    wr(8'h18, 32'h0); `CHK(core_cfg.pwr_on, 1'b0)
    wr(8'h3c, 32'h0000_00ff); `CHK(resp, RESP_SLV)
    rd(8'h3c); `CHK(resp, RESP_SLV)
    wr(8'h18, 32'h0000_0018);
    rd(8'h18); `CHK(rv, 32'h0000_0018)
    wr(8'h18, 32'h0000_0008);
    rd(8'h18); `CHK(rv[4], 1'b1)
    rd(8'h20); `CHK(rv, 32'h0)
    do rd(8'h18); while (rv[4] !== 1'b0);
    rd(8'h20); `CHK(rv, 32'h0000_00a5)
    rd(8'h24); `CHK(rv, 32'h0000_003c)
    rd(8'h2c); `CHK(rv[0], 1'b1)
    wr(8'h2c, 32'h1); rd(8'h2c); `CHK(rv[0], 1'b0)
    wr(8'h28, 32'h0000_0102); repeat (4) @(posedge ref_clk);
    `CHK({pin_func, pin_analog, ext_int_q}, {PF_INT, 8'h00, 1'b1})
    ext_int_pin <= 1'b0;
    repeat (4) @(posedge ref_clk);
    `CHK(ext_int_q, 1'b0)
    wr(8'h28, 32'h0000_0002); repeat (4) @(posedge ref_clk);
    `CHK({pin_func, pin_analog, ext_int_q}, {PF_ANA, 8'h02, 1'b0})
    wr(8'h28, 32'h0); repeat (2) @(posedge ref_clk);
    `CHK({pin_func, pin_analog}, {PF_GPIO, 8'h00})
    // reset in mid conversion: held three edges so no stale edge reaches the checks
    wr(8'h18, 32'h0000_0018);
    repeat (5) @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    `CHK(core_cfg.pwr_on, 1'b0)
    rd(8'h18);
    `CHK(rv, 32'h0)
    rd(8'h20);
    `CHK(rv, 32'h0)
    tally_and_finish();
  end
endmodule
